/* verilog/msc_pkg.sv */
// Constants, codes and state types shared by the module control logic.
`default_nettype none
package msc_pkg;

    // ========================================================
    // Timing.
    localparam int CLK_HZ = 50_000_000;
    localparam int BAUD = 9600;
    localparam int BIT_CYCLES = CLK_HZ / BAUD;
    localparam int SELFCHK_US = 100;
    localparam int SELFCHK_CYCLES = (CLK_HZ / 1_000_000) * SELFCHK_US;
    localparam int DATA_BITS = 8;

    // ========================================================
    // Register byte offsets on the APB.
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_SETTING = 12'h004;
    localparam logic [11:0] OFS_RXDATA = 12'h008;
    localparam logic [11:0] OFS_TXDATA = 12'h00c;
    localparam logic [11:0] OFS_INT_STAT = 12'h010;
    localparam logic [11:0] OFS_INT_CLR = 12'h014;
    localparam logic [11:0] OFS_INT_EN = 12'h018;

    // ========================================================
    // Field positions and reset values.
    localparam int CTRL_STATUS_BIT = 2;
    localparam int RX_VALID_BIT = 8;
    localparam logic [1:0] CTRL_PAR_RST = 2'h0;
    localparam logic [4:0] INT_EN_RST = 5'h00;
    localparam logic CTS_LEVEL = 1'b0;

    // Parity codes of the parity_select_command field.
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;

    // Selection codes: lowest, middle, highest.
    localparam logic [1:0] SEL_LO = 2'h0;
    localparam logic [1:0] SEL_MID = 2'h1;
    localparam logic [1:0] SEL_HI = 2'h2;

    // Interrupt event bit positions.
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_OVL = 3;
    localparam int IRQ_SET = 4;
    localparam int IRQ_W = 5;

    // Button order: gain left, gain right, bandwidth left, right.
    localparam int BTN_W = 4;

    // ========================================================
    // State types.
    typedef enum logic [2:0]
    {
        SER_IDLE = 3'h0,
        SER_START = 3'h1,
        SER_DATA = 3'h3,
        SER_PAR = 3'h2,
        SER_STOP = 3'h6
    } msc_ser_st_t;

    typedef enum logic [1:0]
    {
        RS_WAIT = 2'h0,
        RS_READ = 2'h1,
        RS_RUN = 2'h3
    } msc_rst_st_t;

endpackage
`default_nettype wire

/* verilog/msc_sync.sv */
// Two-stage synchroniser with rising-edge detect for pin inputs.
`timescale 1ns/1ps
`default_nettype none

module msc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_srst,
    // Asynchronous pins and their synchronised forms.
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] prev;

    // The first stage feeds only the second, so metastability stays put.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            meta <= '0;
            o_level <= '0;
            prev <= '0;
        end
        else
        begin
            meta <= i_pin;
            o_level <= meta;
            prev <= o_level;
        end
    end

    // Edge pulses are taken only from the settled stages.
    assign o_rise = o_level & ~prev;

endmodule
`default_nettype wire

/* verilog/msc_ctrl.sv */
// Module control: inverted serial link, panel settings, NVM, APB.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module msc_ctrl #(
    parameter int BIT_CYCLES = msc_pkg::BIT_CYCLES,
    parameter int SELFCHK_CYCLES = msc_pkg::SELFCHK_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_srst,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    // Serial link pins.
    input wire logic i_ser_rx_pin,
    output logic o_ser_tx_pin,
    input wire logic i_rts_pin,
    output logic o_cts_pin,
    output logic o_status_n,
    // Front panel.
    input wire logic [msc_pkg::BTN_W-1:0] i_btn,
    input wire logic i_overload_indicator_det,
    output logic o_overload_indicator,
    output logic [1:0] o_gain_sel,
    output logic [1:0] o_bw_sel,
    // Non-volatile store.
    output logic o_nvm_rd,
    output logic o_nvm_wr,
    output logic [3:0] o_nvm_wdata,
    input wire logic i_nvm_ack,
    input wire logic [3:0] i_nvm_rdata,
    // Interrupt.
    output logic o_irq
);
    import msc_pkg::*;

    // ========================================================
    // Pin synchronisers.
    logic [5:0] sync_lvl;
    logic [5:0] sync_rise;

    msc_sync #(.WIDTH(6)) u_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_pin({i_btn, i_overload_indicator_det, i_ser_rx_pin}),
        .o_level(sync_lvl),
        .o_rise(sync_rise)
    );

    // Pin high is logic zero on the link.
    logic rx_in;
    assign rx_in = ~sync_lvl[0];

    // ========================================================
    // APB decode. One wait state lets every output come from a flop.
    logic acc;
    logic fire;
    logic wr_fire;
    logic hit;
    logic [31:0] rd_mux;
    logic [1:0] ctrl_par;
    logic [7:0] rx_data;
    logic rx_valid;
    logic [IRQ_W-1:0] int_stat;
    logic [IRQ_W-1:0] int_en;
    msc_ser_st_t tx_st;
    msc_ser_st_t rx_st;
    msc_rst_st_t rs_st;

    assign acc = i_psel & i_penable;
    assign fire = acc & o_pready;
    assign wr_fire = fire & i_pwrite & hit;

    // Read mux and decode; unmapped addresses answer with pslverr.
    always_comb
    begin
        hit = 1'b1;
        rd_mux = '0;
        unique case (i_paddr)
            OFS_CTRL: rd_mux = {29'h0, ~o_status_n, ctrl_par};
            OFS_SETTING: rd_mux = {26'h0, rs_st == RS_RUN,
                o_overload_indicator, o_bw_sel, o_gain_sel};
            OFS_RXDATA: rd_mux = {23'h0, rx_valid, rx_data};
            OFS_TXDATA: rd_mux = {31'h0, tx_st != SER_IDLE};
            OFS_INT_STAT: rd_mux = {27'h0, int_stat};
            OFS_INT_CLR: rd_mux = '0;
            OFS_INT_EN: rd_mux = {27'h0, int_en};
            default: hit = 1'b0;
        endcase
    end

    // Bus answer: pready rises one cycle into the access phase.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
        end
        else
        begin
            o_pready <= acc & ~o_pready;
            if (acc & ~o_pready)
            begin
                o_prdata <= i_pwrite ? 32'h0 : rd_mux;
                o_pslverr <= ~hit;
            end
        end
    end

    // Control register; baud and width have no control bits at all.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            ctrl_par <= CTRL_PAR_RST;
            o_status_n <= 1'b1;
        end
        else if (wr_fire && i_paddr == OFS_CTRL)
        begin
            if (i_pwdata[1:0] != 2'h3)
                ctrl_par <= i_pwdata[1:0];
            o_status_n <= ~i_pwdata[CTRL_STATUS_BIT];
        end
    end

    // Handshake input is never read; the output stays at one level.
    always_ff @(posedge i_clk)
    begin
        o_cts_pin <= CTS_LEVEL;
    end

    // ========================================================
    // Transmitter.
    logic [15:0] tx_cnt;
    logic [7:0] tx_sh;
    logic [2:0] tx_bits;
    logic tx_parbit;
    logic tx_usepar;
    logic tx_tick;
    logic tx_go;
    logic tx_done;

    assign tx_tick = tx_cnt == 16'(BIT_CYCLES - 1);
    assign tx_go = wr_fire && i_paddr == OFS_TXDATA && tx_st == SER_IDLE;
    assign tx_done = tx_st == SER_STOP && tx_tick;

    // Bit timer; it restarts on every bit boundary.
    always_ff @(posedge i_clk)
    begin
        if (i_srst || tx_st == SER_IDLE || tx_tick)
            tx_cnt <= '0;
        else
            tx_cnt <= tx_cnt + 16'h0001;
    end

    // Frame sequencer. The pin carries the inverse of each bit.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            tx_st <= SER_IDLE;
            tx_sh <= '0;
            tx_bits <= '0;
            tx_parbit <= 1'b0;
            tx_usepar <= 1'b0;
            o_ser_tx_pin <= 1'b0;
        end
        else
        begin
            unique case (tx_st)
                SER_IDLE:
                    if (tx_go)
                    begin
                        tx_st <= SER_START;
                        tx_sh <= i_pwdata[7:0];
                        tx_usepar <= ctrl_par != PAR_NONE;
                        tx_parbit <= (^i_pwdata[7:0]) ^
                            (ctrl_par == PAR_ODD);
                        o_ser_tx_pin <= 1'b1;
                    end
                SER_START:
                    if (tx_tick)
                    begin
                        tx_st <= SER_DATA;
                        tx_bits <= '0;
                        o_ser_tx_pin <= ~tx_sh[0];
                        tx_sh <= {1'b0, tx_sh[7:1]};
                    end
                SER_DATA:
                    if (tx_tick)
                    begin
                        if (tx_bits == 3'(DATA_BITS - 1))
                        begin
                            tx_st <= tx_usepar ? SER_PAR : SER_STOP;
                            o_ser_tx_pin <= tx_usepar ? ~tx_parbit : 1'b0;
                        end
                        else
                        begin
                            tx_bits <= tx_bits + 3'h1;
                            o_ser_tx_pin <= ~tx_sh[0];
                            tx_sh <= {1'b0, tx_sh[7:1]};
                        end
                    end
                SER_PAR:
                    if (tx_tick)
                    begin
                        tx_st <= SER_STOP;
                        o_ser_tx_pin <= 1'b0;
                    end
                SER_STOP:
                    if (tx_tick)
                        tx_st <= SER_IDLE;
                default: tx_st <= SER_IDLE;
            endcase
        end
    end

    // ========================================================
    // Receiver. Samples at mid-bit after a half-bit start check.
    logic [15:0] rx_cnt;
    logic [7:0] rx_sh;
    logic [2:0] rx_bits;
    logic rx_perr;
    logic rx_tick;
    logic rx_half;
    logic rx_got;
    logic rx_err;
    logic rx_pop;

    assign rx_tick = rx_cnt == 16'(BIT_CYCLES - 1);
    assign rx_half = rx_cnt == 16'(BIT_CYCLES / 2 - 1);
    assign rx_pop = fire & ~i_pwrite & (i_paddr == OFS_RXDATA);

    // Timer restarts at the start check and at each sampled bit.
    always_ff @(posedge i_clk)
    begin
        if (i_srst || rx_st == SER_IDLE || rx_tick ||
            (rx_st == SER_START && rx_half))
            rx_cnt <= '0;
        else
            rx_cnt <= rx_cnt + 16'h0001;
    end

    // Frame sequencer; a start that does not hold is dropped.
    always_ff @(posedge i_clk)
    begin
        rx_got <= 1'b0;
        rx_err <= 1'b0;
        if (i_srst)
        begin
            rx_st <= SER_IDLE;
            rx_sh <= '0;
            rx_bits <= '0;
            rx_perr <= 1'b0;
            rx_data <= '0;
        end
        else
        begin
            unique case (rx_st)
                SER_IDLE:
                    if (!rx_in)
                        rx_st <= SER_START;
                SER_START:
                    if (rx_half)
                    begin
                        rx_st <= rx_in ? SER_IDLE : SER_DATA;
                        rx_bits <= '0;
                        rx_perr <= 1'b0;
                    end
                SER_DATA:
                    if (rx_tick)
                    begin
                        rx_sh <= {rx_in, rx_sh[7:1]};
                        rx_bits <= rx_bits + 3'h1;
                        if (rx_bits == 3'(DATA_BITS - 1))
                            rx_st <= ctrl_par == PAR_NONE ? SER_STOP
                                                          : SER_PAR;
                    end
                SER_PAR:
                    if (rx_tick)
                    begin
                        rx_perr <= ((^rx_sh) ^ rx_in) !=
                            (ctrl_par == PAR_ODD);
                        rx_st <= SER_STOP;
                    end
                SER_STOP:
                    if (rx_tick)
                    begin
                        rx_st <= SER_IDLE;
                        rx_data <= rx_sh;
                        rx_got <= 1'b1;
                        rx_err <= !rx_in || rx_perr || rx_valid;
                    end
                default: rx_st <= SER_IDLE;
            endcase
        end
    end

    // Byte-held flag: a new byte wins over a read in the same cycle.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            rx_valid <= 1'b0;
        else if (rx_got)
            rx_valid <= 1'b1;
        else if (rx_pop)
            rx_valid <= 1'b0;
    end

    // ========================================================
    // Settings: restore after self-check, then panel buttons.
    logic [15:0] rs_cnt;
    logic gain_dn;
    logic gain_up;
    logic bw_dn;
    logic bw_up;
    logic set_chg;
    logic [1:0] next_gain;
    logic [1:0] next_bw;

    assign gain_dn = sync_rise[2] & ~sync_rise[3] & (o_gain_sel != SEL_LO);
    assign gain_up = sync_rise[3] & ~sync_rise[2] & (o_gain_sel != SEL_HI);
    assign bw_dn = sync_rise[4] & ~sync_rise[5] & (o_bw_sel != SEL_LO);
    assign bw_up = sync_rise[5] & ~sync_rise[4] & (o_bw_sel != SEL_HI);

    // Ends of the range saturate instead of wrapping.
    always_comb
    begin
        next_gain = o_gain_sel;
        next_bw = o_bw_sel;
        if (gain_dn)
            next_gain = o_gain_sel - 2'h1;
        else if (gain_up)
            next_gain = o_gain_sel + 2'h1;
        if (bw_dn)
            next_bw = o_bw_sel - 2'h1;
        else if (bw_up)
            next_bw = o_bw_sel + 2'h1;
    end

    assign set_chg = rs_st == RS_RUN && (gain_dn | gain_up | bw_dn | bw_up);

    // A stored code of 3 is corrupt and falls back to the lowest.
    always_ff @(posedge i_clk)
    begin
        o_nvm_rd <= 1'b0;
        o_nvm_wr <= 1'b0;
        if (i_srst)
        begin
            rs_st <= RS_WAIT;
            rs_cnt <= '0;
            o_gain_sel <= SEL_LO;
            o_bw_sel <= SEL_LO;
            o_nvm_wdata <= '0;
        end
        else
        begin
            unique case (rs_st)
                RS_WAIT:
                    if (rs_cnt == 16'(SELFCHK_CYCLES - 1))
                    begin
                        rs_st <= RS_READ;
                        o_nvm_rd <= 1'b1;
                    end
                    else
                        rs_cnt <= rs_cnt + 16'h0001;
                RS_READ:
                    if (i_nvm_ack)
                    begin
                        rs_st <= RS_RUN;
                        o_gain_sel <= i_nvm_rdata[1:0] == 2'h3 ? SEL_LO
                                      : i_nvm_rdata[1:0];
                        o_bw_sel <= i_nvm_rdata[3:2] == 2'h3 ? SEL_LO
                                    : i_nvm_rdata[3:2];
                    end
                RS_RUN:
                    if (set_chg)
                    begin
                        o_gain_sel <= next_gain;
                        o_bw_sel <= next_bw;
                        o_nvm_wr <= 1'b1;
                        o_nvm_wdata <= {next_bw, next_gain};
                    end
                default: rs_st <= RS_WAIT;
            endcase
        end
    end

    // Overload lamp follows the synchronised detector with one cycle of delay.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_overload_indicator <= 1'b0;
        else
            o_overload_indicator <= sync_lvl[1];
    end

    // ========================================================
    // Interrupts: sticky status, set wins over a clear.
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;

    assign ev = {set_chg, sync_rise[1], rx_err, tx_done, rx_got};
    assign clr = (wr_fire && i_paddr == OFS_INT_CLR) ?
                 i_pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            int_stat <= '0;
            int_en <= INT_EN_RST;
            o_irq <= 1'b0;
        end
        else
        begin
            int_stat <= (int_stat & ~clr) | ev;
            if (wr_fire && i_paddr == OFS_INT_EN)
                int_en <= i_pwdata[IRQ_W-1:0];
            o_irq <= |(int_stat & int_en);
        end
    end

    // ========================================================
    // Checks.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    property p_tx_idle;
        tx_st == SER_IDLE && $past(tx_st) == SER_IDLE |-> !o_ser_tx_pin;
    endproperty
    a_tx_idle: assert property (p_tx_idle)
        else $error("Idle serial output not at ground level.");

    property p_tx_start;
        tx_go |=> (o_ser_tx_pin && tx_st == SER_START) [*2];
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("Start bit not driven high on the pin.");

    // The start bit lasts thousands of cycles at the real rate, so it is
    // counted here rather than written out as one long delay.
    logic [15:0] start_len;

    always_ff @(posedge i_clk)
    begin
        if (i_srst || tx_st != SER_START)
            start_len <= '0;
        else
            start_len <= start_len + 16'h0001;
    end

    property p_bit_len;
        $past(tx_st) == SER_START && tx_st == SER_DATA |->
            start_len == 16'(BIT_CYCLES);
    endproperty
    a_bit_len: assert property (p_bit_len)
        else $error("Start bit length differs from one baud period.");

    property p_par_keep;
        wr_fire && i_paddr == OFS_CTRL && i_pwdata[1:0] == 2'h3
            |=> $stable(ctrl_par);
    endproperty
    a_par_keep: assert property (p_par_keep)
        else $error("Reserved parity code altered the parity mode.");

    property p_status;
        wr_fire && i_paddr == OFS_CTRL |=>
            o_status_n == !$past(i_pwdata[CTRL_STATUS_BIT]);
    endproperty
    a_status: assert property (p_status)
        else $error("Status line does not follow the request bit.");

    property p_restore;
        rs_st == RS_READ && i_nvm_ack && i_nvm_rdata[1:0] != 2'h3 |=>
            o_gain_sel == $past(i_nvm_rdata[1:0]) && rs_st == RS_RUN;
    endproperty
    a_restore: assert property (p_restore)
        else $error("Stored gain not restored at power-on.");

    property p_sel_legal;
        o_gain_sel != 2'h3 && o_bw_sel != 2'h3;
    endproperty
    a_sel_legal: assert property (p_sel_legal)
        else $error("Gain or bandwidth outside its three choices.");

    property p_overload_indicator;
        o_overload_indicator == $past(sync_lvl[1]);
    endproperty
    a_overload_indicator: assert property (p_overload_indicator)
        else $error("Overload lamp does not follow the detector.");

    property p_wb;
        $past(rs_st) == RS_RUN && $changed(o_bw_sel) |->
            o_nvm_wr && o_nvm_wdata[3:2] == o_bw_sel;
    endproperty
    a_wb: assert property (p_wb)
        else $error("Bandwidth change not written back to the store.");

    property p_cts;
        o_cts_pin == CTS_LEVEL ##1 $stable(o_cts_pin);
    endproperty
    a_cts: assert property (p_cts)
        else $error("Handshake output left its fixed level.");

endmodule
`default_nettype wire

/* verification/msc_host.sv */
// Host serial port model: inverted-level link, eight bits, one stop.
`timescale 1ns/1ps
`default_nettype none

module msc_host #(
    parameter int BIT_CYCLES = 16
) (
    // Clock.
    input wire logic i_clk,
    // Link pins as seen from the host.
    input wire logic i_tx_pin,
    output logic o_rx_pin
);
    // ========================================================
    // Host state; no handshake lines exist here at all.
    logic [1:0] par = 2'h0;
    logic [7:0] got = 8'h00;
    int got_n = 0;

    initial o_rx_pin = 1'b0;

    // Sends one frame; the pin carries the inverse of each bit.
    task automatic send(input logic [7:0] b);
        logic [10:0] f;
        int n;
        f = {2'b11, b, 1'b0};
        n = 10;
        if (par != 2'h0)
        begin
            f[9] = (^b) ^ (par == 2'h1);
            n = 11;
        end
        for (int i = 0; i < n; i++)
        begin
            @(posedge i_clk);
            o_rx_pin <= ~f[i];
            repeat (BIT_CYCLES - 1) @(posedge i_clk);
        end
    endtask

    // Samples device frames at mid-bit, skipping any parity bit.
    always
    begin
        @(posedge i_clk);
        while (i_tx_pin !== 1'b1) @(posedge i_clk);
        repeat (BIT_CYCLES / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYCLES) @(posedge i_clk);
            got[i] = ~i_tx_pin;
        end
        repeat (BIT_CYCLES * ((par != 2'h0) ? 2 : 1)) @(posedge i_clk);
        got_n++;
    end
endmodule

`default_nettype wire

/* verification/module_serial_and_setting_control_test.sv */
// Self-checking bench of the module control logic.
`timescale 1ns/1ps
`default_nettype none

module module_serial_and_setting_control_test;
    import msc_pkg::*;
    localparam int BC = 16;
    localparam logic [9:0] TBL [9] = '{10'h1a1, 10'h1a1, 10'h3a1,
        10'h292, 10'h053, 10'h014, 10'h014, 10'h205, 10'h205};
    logic clk, tx, cts, stat_n, ovl_ind, nvm_rd, nvm_wr, irq, pready;
    logic srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pslverr, perr, rx, overload_indicator = 1'b0, nvm_ack = 1'b0;
    logic [3:0] btn = 4'h0, nvm_rdata = 4'h0, nvm_wd;
    logic [1:0] gain, bw;
    int fail_count = 0, checks_done = 0, wr_n = 0, n;

    msc_ctrl #(.BIT_CYCLES(BC), .SELFCHK_CYCLES(8)) i_msc_ctrl (
        .i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
        .i_ser_rx_pin(rx), .o_ser_tx_pin(tx), .i_rts_pin(1'b0),
        .o_cts_pin(cts), .o_status_n(stat_n), .i_btn(btn),
        .i_overload_indicator_det(overload_indicator), .o_overload_indicator(ovl_ind),
        .o_gain_sel(gain), .o_bw_sel(bw), .o_nvm_rd(nvm_rd),
        .o_nvm_wr(nvm_wr), .o_nvm_wdata(nvm_wd), .i_nvm_ack(nvm_ack),
        .i_nvm_rdata(nvm_rdata), .o_irq(irq));
    msc_host #(.BIT_CYCLES(BC)) i_msc_host (.i_clk(clk),
        .i_tx_pin(tx), .o_rx_pin(rx));

    // ========================================================
    // Clock, store write counter and hang guard.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) if (nvm_wr === 1'b1) wr_n++;

    // The whole run needs a little over a thousand cycles; this is ample.
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end

    // ========================================================
    // Access and compare tasks.
    task automatic close_out();
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Only the watchdog ends a wait for the answer.
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // ========================================================
    // Test sequence.
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(32'({stat_n, cts, tx, gain, bw, irq}), 32'h80);
        while (nvm_rd !== 1'b1)
            @(posedge clk);
        nvm_ack <= 1'b1;
        nvm_rdata <= 4'h9;
        @(posedge clk);
        nvm_ack <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'({gain, bw}), 32'h6);
        rdc(OFS_SETTING, 32'h29);
        // Button table: {button, gain, bandwidth, store writes}.
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clk);
            btn[TBL[i][9:8]] <= 1'b1;
            repeat (6) @(posedge clk);
            btn <= 4'h0;
            repeat (6) @(posedge clk);
            chk(32'({gain, bw, nvm_wd, wr_n[3:0]}), 32'({TBL[i][7:4],
                TBL[i][5:4], TBL[i][7:6], TBL[i][3:0]}));
        end
        apb(1'b1, OFS_INT_CLR, 32'h1f);
        overload_indicator <= 1'b1;
        repeat (5) @(posedge clk);
        chk(32'(ovl_ind), 32'h1);
        rdc(OFS_SETTING, 32'h30);
        chk(32'(irq), 32'h0);
        apb(1'b1, OFS_INT_EN, 32'h08);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        apb(1'b1, OFS_INT_CLR, 32'h08);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        overload_indicator <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h4);
        chk(32'(ovl_ind), 32'h0);
        // The status line moves on the commit edge; look one edge later.
        @(posedge clk);
        chk(32'(stat_n), 32'h0);
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b0, 12'h01c, 32'h0);
        chk(32'({stat_n, perr}), 32'h3);
        n = i_msc_host.got_n;
        apb(1'b1, OFS_TXDATA, 32'ha5);
        repeat (12 * BC) @(posedge clk);
        chk({24'(i_msc_host.got_n - n), i_msc_host.got}, 32'h1a5);
        rdc(OFS_TXDATA, 32'h0);
        // Receive once under every parity code.
        for (int p = 0; p < 3; p++)
        begin
            apb(1'b1, OFS_CTRL, p);
            apb(1'b1, OFS_INT_CLR, 32'h1f);
            i_msc_host.par = p[1:0];
            i_msc_host.send(8'h5a ^ p[7:0]);
            repeat (2 * BC) @(posedge clk);
            rdc(OFS_RXDATA, 32'h15a ^ p);
            rdc(OFS_INT_STAT, 32'h1);
        end
        // Reserved parity code must leave even parity in place.
        apb(1'b1, OFS_CTRL, 32'h3);
        rdc(OFS_CTRL, 32'h2);
        close_out();
    end
endmodule

`default_nettype wire
